// ---- rsi_cfg.svh ----
`ifndef RSI_CFG_SVH
`define RSI_CFG_SVH
// register byte offsets, compared on haddr[7:0]
`define RSI_CTRL_OFS 8'h00
`define RSI_STATUS_OFS 8'h04
`define RSI_MODE_OFS 8'h08
// control register fields and reset value
`define RSI_CTRL_EN_BIT 0
`define RSI_CTRL_USE_EXT_BIT 1
`define RSI_CTRL_RST 2'h0
// post-success lockout delay in hclk cycles
`define RSI_LOCKOUT_CYCLES 1000
// ahb encodings
`define RSI_HSIZE_WORD 3'h2
`define RSI_HRESP_OKAY 1'h0
`endif

// ---- rsi_pkg.sv ----
`default_nettype none
package rsi_pkg;
   localparam int RSI_NUM_SHOTS = 5;

   typedef enum logic [1:0] {
      MODE_INHIBIT = 2'b00,
      MODE_READY = 2'b01,
      MODE_RUNNING = 2'b10,
      MODE_LOCKED = 2'b11
   } rsi_mode_type;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_ARCING = 2'b01,
      PH_DEAD = 2'b10,
      PH_RECLAIM = 2'b11
   } rsi_phase_type;

   // binary inputs from elsewhere in the device, synchronised inside
   typedef struct packed {
      logic trip_request_fifth;
      logic trip_request_fourth;
      logic trip_request_third;
      logic trip_request_second;
      logic trip_request_first;
      logic critical_request;
      logic lock_request;
      logic manual_reset;
      logic external_enable_input;
   } rsi_pins_type;

   // timing state of the reclose sequencer, same clock
   typedef struct packed {
      rsi_phase_type phase;
      logic [2:0] shot_num;
      logic last_shot_closed;
      logic final_trip_done;
      logic seq_success;
   } rsi_seq_type;

   typedef struct packed {
      logic reclose_enabled_ind;
      logic reclose_disabled_ind;
      logic reclose_in_progress_ind;
      logic dead_interval_ind;
      logic arcing_interval_ind;
      logic reclaim_interval_ind;
      logic seq_running_ind;
      logic seq_finished_ind;
      logic final_trip_ind;
      logic seq_ready_ind;
      logic post_success_lockout_ind;
      logic seq_inhibit_ind;
      logic seq_locked_ind;
      logic [RSI_NUM_SHOTS-1:0] request_active_ind;
      logic [RSI_NUM_SHOTS-1:0] shot_running_ind;
   } rsi_ind_type;
endpackage
`default_nettype wire

// ---- rsi_reclose_status_indicator.sv ----
// Functional notes
// - only indications are produced; no breaker open or close command leaves here
// - enabled indication follows the enabled state of the reclose function
// - disabled indication only when external enable is used and inactive
// - in-progress and dead-time indications both show during the dead interval
// - one request-active indication per request input of the running shot
// - one shot-running indication per shot number one to five
// - running indication while in running mode
// - finished indication while last-shot reclose is reported in running mode, cleared by final trip or reclaim end
// - final-trip indication once the final trip has been issued
// - arcing indication while the arcing interval is timed
// - reclaim indication while the reclaim interval is timed
// - ready indication while prepared to start a sequence
// - post-success lockout indication on a fault inside the lockout delay
// - during post-success lockout no new sequence starts; go locked instead
// - inhibit indication while in inhibit mode
// - locked indication while in locked mode
// - first request wins over all others, fifth loses to all
// - critical request locks immediately
// - manual reset releases the locked mode
`include "rsi_cfg.svh"
`default_nettype none
module rsi_reclose_status_indicator #(
   parameter int LOCKOUT_CYCLES = `RSI_LOCKOUT_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire rsi_pkg::rsi_pins_type pins_i,
   input wire rsi_pkg::rsi_seq_type seq_i,
   output rsi_pkg::rsi_ind_type ind_o
);
   import rsi_pkg::*;

   // elaboration check: the 16-bit counter must load a non-zero value
   if (LOCKOUT_CYCLES < 1 || LOCKOUT_CYCLES > 65535)
   begin : g_lockout_range
      $error("LOCKOUT_CYCLES out of range");
   end

   localparam logic [15:0] LOCKOUT_LOAD = 16'(LOCKOUT_CYCLES);

   function automatic logic [RSI_NUM_SHOTS-1:0] prio_onehot(input logic [RSI_NUM_SHOTS-1:0] v);
      logic [RSI_NUM_SHOTS-1:0] r;
      r = '0;
      for (int i = RSI_NUM_SHOTS - 1; i >= 0; i--)
      begin
         if (v[i])
            r = RSI_NUM_SHOTS'(1) << i;
      end
      return r;
   endfunction

   function automatic logic [RSI_NUM_SHOTS-1:0] shot_onehot(input logic [2:0] n);
      logic [RSI_NUM_SHOTS-1:0] r;
      r = '0;
      for (int i = 0; i < RSI_NUM_SHOTS; i++)
      begin
         if (n == 3'(i + 1))
            r[i] = 1'b1;
      end
      return r;
   endfunction

   rsi_pins_type pin_meta_r;
   rsi_pins_type pin_s_r;
   rsi_mode_type mode_r;
   rsi_ind_type ind_r;
   rsi_ind_type ind_nxt;
   logic [1:0] ctrl_r;
   logic [15:0] lockout_cnt_r;
   logic post_lockout_r;
   logic final_trip_r;
   logic [RSI_NUM_SHOTS-1:0] req_idx_r;
   logic [7:0] addr_r;
   logic wr_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic hresp_r;
   logic enabled_w;
   logic use_ext_w;
   logic [RSI_NUM_SHOTS-1:0] req_vec;
   logic [RSI_NUM_SHOTS-1:0] win_w;
   logic any_req;
   logic force_lock;
   logic start_req;
   logic lockout_hit;
   logic release_w;
   logic addr_ok;
   logic [1:0] ctrl_view;

   // input synchroniser: the first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_meta_r <= '0;
         pin_s_r <= '0;
      end
      else
      begin
         pin_meta_r <= pins_i;
         pin_s_r <= pin_meta_r;
      end
   end

   assign use_ext_w = ctrl_r[`RSI_CTRL_USE_EXT_BIT];
   assign enabled_w = ctrl_r[`RSI_CTRL_EN_BIT] & (~use_ext_w | pin_s_r.external_enable_input);
   assign req_vec = {pin_s_r.trip_request_fifth, pin_s_r.trip_request_fourth,
                     pin_s_r.trip_request_third, pin_s_r.trip_request_second,
                     pin_s_r.trip_request_first};
   assign win_w = prio_onehot(req_vec);
   assign any_req = |req_vec;
   assign force_lock = pin_s_r.critical_request | pin_s_r.lock_request | seq_i.final_trip_done;
   assign start_req = enabled_w && !force_lock && mode_r == MODE_READY && any_req;
   assign lockout_hit = start_req && lockout_cnt_r != 16'h0000;
   assign release_w = enabled_w && !force_lock && mode_r == MODE_LOCKED && pin_s_r.manual_reset;

   // mode sequencing
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mode_r <= MODE_INHIBIT;
      else if (!enabled_w)
         mode_r <= MODE_INHIBIT;
      else if (force_lock)
         mode_r <= MODE_LOCKED;
      else
      begin
         case (mode_r)
            MODE_INHIBIT: mode_r <= MODE_READY;
            MODE_READY:
            begin
               if (lockout_hit)
                  mode_r <= MODE_LOCKED;
               else if (any_req)
                  mode_r <= MODE_RUNNING;
            end
            MODE_RUNNING:
            begin
               if (seq_i.seq_success)
                  mode_r <= MODE_READY;
            end
            MODE_LOCKED:
            begin
               if (pin_s_r.manual_reset)
                  mode_r <= MODE_READY;
            end
            default: mode_r <= MODE_INHIBIT;
         endcase
      end
   end

   // lockout delay after a successful sequence
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         lockout_cnt_r <= 16'h0000;
      else if (mode_r == MODE_RUNNING && seq_i.seq_success)
         lockout_cnt_r <= LOCKOUT_LOAD;
      else if (lockout_cnt_r != 16'h0000)
         lockout_cnt_r <= lockout_cnt_r - 16'h0001;
   end

   // sticky flags: a new setting event wins over the release
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         post_lockout_r <= 1'b0;
         final_trip_r <= 1'b0;
      end
      else
      begin
         if (lockout_hit)
            post_lockout_r <= 1'b1;
         else if (release_w || mode_r == MODE_INHIBIT)
            post_lockout_r <= 1'b0;
         if (seq_i.final_trip_done)
            final_trip_r <= 1'b1;
         else if (release_w || mode_r == MODE_INHIBIT)
            final_trip_r <= 1'b0;
      end
   end

   // winning request is latched at sequence start
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         req_idx_r <= '0;
      else if (start_req && !lockout_hit)
         req_idx_r <= win_w;
      else if (mode_r != MODE_RUNNING)
         req_idx_r <= '0;
   end

   // indication decode; breaker commands are not produced here
   always_comb
   begin
      ind_nxt = '0;
      ind_nxt.reclose_enabled_ind = enabled_w;
      ind_nxt.reclose_disabled_ind = use_ext_w & ~pin_s_r.external_enable_input;
      if (mode_r == MODE_RUNNING)
      begin
         ind_nxt.seq_running_ind = 1'b1;
         ind_nxt.reclose_in_progress_ind = seq_i.phase == PH_DEAD;
         ind_nxt.dead_interval_ind = seq_i.phase == PH_DEAD;
         ind_nxt.arcing_interval_ind = seq_i.phase == PH_ARCING;
         ind_nxt.reclaim_interval_ind = seq_i.phase == PH_RECLAIM;
         ind_nxt.seq_finished_ind = seq_i.last_shot_closed;
         ind_nxt.request_active_ind = req_idx_r;
         ind_nxt.shot_running_ind = shot_onehot(seq_i.shot_num);
      end
      ind_nxt.final_trip_ind = final_trip_r;
      ind_nxt.post_success_lockout_ind = post_lockout_r;
      ind_nxt.seq_ready_ind = mode_r == MODE_READY;
      ind_nxt.seq_inhibit_ind = mode_r == MODE_INHIBIT;
      ind_nxt.seq_locked_ind = mode_r == MODE_LOCKED;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ind_r <= '0;
      else
         ind_r <= ind_nxt;
   end

   assign ind_o = ind_r;

   // ahb-lite slave, zero wait states, always okay
   assign addr_ok = hsel && htrans[1] && hready;
   assign ctrl_view = (wr_r && addr_r == `RSI_CTRL_OFS) ? hwdata[1:0] : ctrl_r;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         addr_r <= 8'h00;
         wr_r <= 1'b0;
      end
      else if (hready)
      begin
         addr_r <= haddr[7:0];
         wr_r <= addr_ok && hwrite && hsize == `RSI_HSIZE_WORD;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctrl_r <= `RSI_CTRL_RST;
      else if (wr_r && addr_r == `RSI_CTRL_OFS)
         ctrl_r <= hwdata[1:0];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_r <= 32'h0000_0000;
      else if (addr_ok && !hwrite)
      begin
         case (haddr[7:0])
            `RSI_CTRL_OFS: hrdata_r <= {30'h0000_0000, ctrl_view};
            `RSI_STATUS_OFS: hrdata_r <= {9'h000, ind_r};
            `RSI_MODE_OFS: hrdata_r <= {25'h000_0000, req_idx_r, mode_r};
            default: hrdata_r <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout_r <= 1'b1;
         hresp_r <= `RSI_HRESP_OKAY;
      end
      else
      begin
         hreadyout_r <= 1'b1;
         hresp_r <= `RSI_HRESP_OKAY;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_enabled;
      ind_r.reclose_enabled_ind == $past(enabled_w);
   endproperty
   a_enabled: assert property (p_enabled) else $error("enabled ind wrong");

   property p_disabled;
      ind_r.reclose_disabled_ind |-> $past(use_ext_w) && !$past(pin_s_r.external_enable_input);
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled ind wrong");

   property p_dead;
      ind_r.dead_interval_ind == ind_r.reclose_in_progress_ind;
   endproperty
   a_dead: assert property (p_dead) else $error("dead and progress differ");

   property p_shot;
      (ind_r.shot_running_ind != '0 || ind_r.request_active_ind != '0) |-> ind_r.seq_running_ind;
   endproperty
   a_shot: assert property (p_shot) else $error("shot ind outside running");

   property p_onehot;
      $onehot0(ind_r.shot_running_ind) && $onehot0(ind_r.request_active_ind)
      && $onehot0({ind_r.seq_ready_ind, ind_r.seq_running_ind,
                   ind_r.seq_locked_ind, ind_r.seq_inhibit_ind});
   endproperty
   a_onehot: assert property (p_onehot) else $error("indications not exclusive");

   property p_crit;
      enabled_w && pin_s_r.critical_request |=> mode_r == MODE_LOCKED ##1 ind_r.seq_locked_ind;
   endproperty
   a_crit: assert property (p_crit) else $error("critical request did not lock");

   property p_release;
      release_w |=> mode_r == MODE_READY ##1 !ind_r.seq_locked_ind && ind_r.seq_ready_ind;
   endproperty
   a_release: assert property (p_release) else $error("manual reset did not release");

   property p_lockout;
      lockout_hit |=> mode_r == MODE_LOCKED && post_lockout_r ##1 ind_r.post_success_lockout_ind;
   endproperty
   a_lockout: assert property (p_lockout) else $error("lockout did not lock");

   property p_prio;
      start_req && !lockout_hit |=> ##1 ind_r.request_active_ind == $past(win_w, 2)
                                        || mode_r != MODE_RUNNING;
   endproperty
   a_prio: assert property (p_prio) else $error("wrong winning request");

   property p_final;
      enabled_w && seq_i.final_trip_done |=> ##1 ind_r.final_trip_ind && ind_r.seq_locked_ind;
   endproperty
   a_final: assert property (p_final) else $error("final trip not shown");

   property p_bus;
      hreadyout && hresp == `RSI_HRESP_OKAY;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer not okay");

   c_run: cover property (ind_r.seq_running_ind && ind_r.dead_interval_ind);
   c_lockout: cover property (ind_r.post_success_lockout_ind);
   c_crit: cover property (mode_r == MODE_READY ##1 pin_s_r.critical_request);
   c_release: cover property (release_w ##2 ind_r.seq_ready_ind);
endmodule
`default_nettype wire

// ---- rsi_seq_model.sv ----
`default_nettype none
module rsi_seq_model
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire rsi_pkg::rsi_seq_type cmd,
   input wire logic running,
   output rsi_pkg::rsi_seq_type seq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import rsi_pkg::*;
   logic ft_r;
   logic ok_r;
   // timers only run while a sequence runs; trip and success leave as single pulses
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         seq_o <= '0;
         ft_r <= 1'b0;
         ok_r <= 1'b0;
      end
      else
      begin
         ft_r <= cmd.final_trip_done;
         ok_r <= cmd.seq_success;
         seq_o.final_trip_done <= cmd.final_trip_done & ~ft_r;
         seq_o.seq_success <= cmd.seq_success & ~ok_r;
         seq_o.phase <= running ? cmd.phase : PH_IDLE;
         seq_o.shot_num <= running ? cmd.shot_num : 3'h0;
         seq_o.last_shot_closed <= running & cmd.last_shot_closed;
      end
   end
endmodule
`default_nettype wire

// ---- tb_reclose_status_indicator.sv ----
`include "rsi_cfg.svh"
`default_nettype none
module tb_reclose_status_indicator;
   timeunit 1ns;
   timeprecision 1ps;
   import rsi_pkg::*;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   rsi_pins_type pins;
   rsi_seq_type cmd;
   rsi_seq_type seq;
   rsi_ind_type ind_o;
   int failures;
   int checks;
   int mode;
   int en;
   int dis;
   int win;
   int ph;
   int shot;
   int last;
   int ft;
   int psl;
   logic [31:0] rd;
   logic [4:0] req;
   logic [2:0] sz;

   rsi_reclose_status_indicator #(.LOCKOUT_CYCLES(8)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins_i(pins),
      .seq_i(seq), .ind_o(ind_o)
   );
   rsi_seq_model seq_u (
      .hclk(hclk), .hresetn(hresetn), .cmd(cmd), .running(ind_o.seq_running_ind),
      .seq_o(seq)
   );

   initial hclk = 1'b0;
   always #4 hclk = ~hclk;

   function automatic rsi_ind_type exp_ind();
      rsi_ind_type e;
      logic run;
      e = '0;
      run = (mode == 2);
      e.reclose_enabled_ind = en[0];
      e.reclose_disabled_ind = dis[0];
      e.reclose_in_progress_ind = run && ph == 2;
      e.dead_interval_ind = run && ph == 2;
      e.arcing_interval_ind = run && ph == 1;
      e.reclaim_interval_ind = run && ph == 3;
      e.seq_running_ind = run;
      e.seq_finished_ind = run && last == 1;
      e.final_trip_ind = ft[0];
      e.seq_ready_ind = (mode == 1);
      e.post_success_lockout_ind = psl[0];
      e.seq_inhibit_ind = (mode == 0);
      e.seq_locked_ind = (mode == 3);
      e.request_active_ind = run ? 5'(1 << win) : 5'h00;
      e.shot_running_ind = (run && shot >= 1) ? 5'(1 << (shot - 1)) : 5'h00;
      return e;
   endfunction

   task automatic end_sim();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // lets synchroniser, mode and indication stages settle, compares mid-cycle,
   // and hands back at a rising edge so the next stimulus lands on the edge
   task automatic settle_chk();
      repeat (6) @(posedge hclk);
      @(negedge hclk);
      chk({9'h000, ind_o}, {9'h000, exp_ind()});
      @(posedge hclk);
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      htrans <= 2'h2;
      hsize <= sz;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic drive_req(input logic [4:0] r);
      @(posedge hclk);
      pins[8:4] <= r;
   endtask

   task automatic manual_rst();
      @(posedge hclk);
      pins.manual_reset <= 1'b1;
      repeat (3) @(posedge hclk);
      pins.manual_reset <= 1'b0;
      mode = 1;
   endtask

   initial
   begin
      repeat (20000) @(posedge hclk);
      failures++;
      end_sim();
   end

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      sz = `RSI_HSIZE_WORD;
      hwdata = '0;
      pins = '0;
      cmd = '0;
      {failures, checks, mode, en, dis, win, ph, shot, last, ft, psl} = '0;
      void'($urandom(32'h882D));
      repeat (20) @(posedge hclk);
      chk({9'h000, ind_o}, 32'h0);
      hresetn <= 1'b1;
      settle_chk();
      ahb(1'b1, `RSI_CTRL_OFS, 32'h1);
      en = 1;
      mode = 1;
      settle_chk();
      ahb(1'b0, `RSI_MODE_OFS, 32'h0);
      chk(rd & 32'h3, 32'h1);
      ahb(1'b0, 8'h40, 32'h0);
      chk({rd[31:1], hresp}, 32'h0);
      ahb(1'b0, `RSI_STATUS_OFS, 32'h0);
      chk(rd, {9'h000, exp_ind()});
      // a byte-sized write must leave the control register alone
      sz = 3'h0;
      ahb(1'b1, `RSI_CTRL_OFS, 32'h0);
      sz = `RSI_HSIZE_WORD;
      ahb(1'b0, `RSI_CTRL_OFS, 32'h0);
      chk(rd, 32'h1);
      ahb(1'b1, `RSI_CTRL_OFS, 32'h3);
      {en, dis, mode} = {32'd0, 32'd1, 32'd0};
      settle_chk();
      @(posedge hclk);
      pins.external_enable_input <= 1'b1;
      {en, dis, mode} = {32'd1, 32'd0, 32'd1};
      settle_chk();
      for (int k = 0; k < 5; k++)
      begin
         req = (5'($urandom) | (5'h01 << k)) & ~((5'h01 << k) - 5'h01);
         drive_req(req);
         mode = 2;
         win = k;
         settle_chk();
         drive_req(5'h00);
         for (int p = 0; p < 4; p++)
         begin
            cmd.phase <= rsi_phase_type'(p);
            cmd.shot_num <= 3'(k + 1);
            ph = p;
            shot = k + 1;
            settle_chk();
         end
         cmd.last_shot_closed <= 1'b1;
         last = 1;
         settle_chk();
         @(posedge hclk);
         cmd <= '0;
         {ph, shot, last} = '0;
         if (k % 2 == 0)
         begin
            @(posedge hclk);
            cmd.seq_success <= 1'b1;
            drive_req(5'h1F);
            mode = 3;
            psl = 1;
            settle_chk();
            drive_req(5'h00);
         end
         else
         begin
            @(posedge hclk);
            cmd.final_trip_done <= 1'b1;
            mode = 3;
            ft = 1;
            settle_chk();
         end
         cmd <= '0;
         manual_rst();
         {psl, ft} = '0;
         settle_chk();
      end
      for (int c = 0; c < 2; c++)
      begin
         // bit 3 is the critical request, bit 2 the locking input
         @(posedge hclk);
         pins[3 - c] <= 1'b1;
         mode = 3;
         settle_chk();
         @(posedge hclk);
         pins[3 - c] <= 1'b0;
         manual_rst();
         settle_chk();
      end
      ahb(1'b1, `RSI_CTRL_OFS, 32'h0);
      {en, mode} = '0;
      settle_chk();
      end_sim();
   end
endmodule
`default_nettype wire
